// file: hw/tbr_gen.sv
// Purpose : Self-test packet generator timing, one byte per byte enable
// Assumes : byte_en is a one-cycle pulse from the byte-rate divider
// Notes   : Length latched at packet start; zero gap acts as a one-byte gap

module tbr_gen
    import tbr_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        byte_en,
    input  wire logic        run,
    input  wire logic [10:0] frame_bytes,
    input  wire logic [7:0]  gap_bytes,
    output logic             gen_byte,
    output logic             gen_sop,
    output logic             gen_done
);

    tbr_gen_state_t state;      // Current phase
    tbr_gen_state_t next_state;
    logic [10:0]    left;       // Bytes left in frame or gap
    logic [10:0]    next_left;
    logic           next_byte;
    logic           next_sop;
    logic           next_done;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_left  = left;
        next_byte  = 1'b0;
        next_sop   = 1'b0;
        next_done  = 1'b0;
        if (!run) begin
            // Stopping mid-frame truncates the packet
            next_state = GEN_IDLE;
        end else if (byte_en) begin
            case (state)
                GEN_IDLE, GEN_GAP: begin
                    if (state == GEN_GAP && left > 11'd1) begin
                        next_left = left - 11'd1;
                    end else if (frame_bytes != 11'd0) begin
                        // Start a frame with the length in force now
                        next_state = GEN_FRAME;
                        next_left  = frame_bytes - 11'd1;
                        next_byte  = 1'b1;
                        next_sop   = 1'b1;
                    end else begin
                        next_state = GEN_IDLE;
                    end
                end
                GEN_FRAME: begin
                    if (left != 11'd0) begin
                        next_left = left - 11'd1;
                        next_byte = 1'b1;
                    end else begin
                        next_done = 1'b1;
                        // The gap byte count replaces the frame count
                        next_left  = {3'b000, gap_bytes};
                        next_state = (gap_bytes == 8'h00) ? GEN_IDLE : GEN_GAP;
                    end
                end
                default: begin
                    next_state = GEN_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state    <= GEN_IDLE;
            left     <= 11'h000;
            gen_byte <= 1'b0;
            gen_sop  <= 1'b0;
            gen_done <= 1'b0;
        end else begin
            state    <= next_state;
            left     <= next_left;
            gen_byte <= next_byte;
            gen_sop  <= next_sop;
            gen_done <= next_done;
        end
    end

endmodule

// file: hw/tbr_pkg.sv
// Purpose : Shared constants and types for the 10Base-T and self-test register bank
// Assumes : Index = byte address / 4, 32-bit AHB-Lite
// Notes   : Offsets, fields, resets, timing counts

package tbr_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_PHY_STATUS    = 8'h10; // Status mirror
    localparam logic [7:0] IDX_SELFTEST_CTRL = 8'h16; // Self-test control bits
    localparam logic [7:0] IDX_TENBASE       = 8'h1a; // tenbase_t_status_control
    localparam logic [7:0] IDX_ERRGAP        = 8'h1b; // selftest_errcount_gap
    localparam logic [7:0] IDX_PKTLEN        = 8'h1c; // selftest_packet_length
    localparam logic [7:0] IDX_IRQ_STATUS    = 8'h20; // Sticky events, write one to clear
    localparam logic [7:0] IDX_IRQ_MASK      = 8'h21; // Event enables, same layout

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int TB_RXTH_BIT   = 13;  // Lower receive threshold enable
    localparam int TB_SQ_LSB     = 9;   // Squelch field 12:9
    localparam int TB_NLP_BIT    = 7;   // Link pulse transmit off
    localparam int TB_POL_BIT    = 4;   // Inverted polarity flag
    localparam int TB_JAB_BIT    = 0;   // Jabber off
    localparam int PS_POL_BIT    = 12;  // Polarity copy in status mirror
    localparam int EG_CLR_BIT    = 15;  // Write one: snapshot, clear
    localparam int EG_CNT_LSB    = 8;   // Error count 15:8
    localparam int CT_RUN_BIT    = 0;   // Generator run
    localparam int CT_CHK_BIT    = 1;   // Checker enable
    localparam int CT_MODE_BIT   = 2;   // checker_count_mode
    localparam int IRQ_POL       = 0;   // Polarity inversion caught
    localparam int IRQ_SAT       = 1;   // Error counter saturated at its top
    localparam int IRQ_PKT       = 2;   // One generated packet finished
    localparam int IRQ_W         = 3;

    // ------------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------------
    localparam logic [7:0]  GAP_RESET   = 8'h7d;   // 125 bytes
    localparam logic [10:0] LEN_RESET   = 11'h5dc; // 1500 bytes
    localparam logic [3:0]  SQ_RESET    = 4'h0;    // 200 mV
    localparam logic [3:0]  SQ_MAX      = 4'h8;    // 600 mV in 50 mV steps
    localparam logic [7:0]  ERR_MAX     = 8'hff;

    // ------------------------------------------------------------------
    // Timing: one byte at 100 Mb/s is 80 ns
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int BYTE_TIME_NS  = 80;
    localparam int BYTE_CYCLES   = (BYTE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       lower_rx_threshold_en; // Reduced receive threshold
        logic [3:0] squelch_level;         // 0 = 200 mV, +50 mV a step
        logic       link_pulse_tx_off;     // Stop normal link pulses
        logic       jabber_off;            // Jabber function off
    } tbr_tenbase_t;

    typedef struct packed {
        logic       valid; // Write data phase pending
        logic [7:0] idx;   // Register index of that write
    } tbr_req_t;

    typedef enum logic [1:0] {GEN_IDLE, GEN_FRAME, GEN_GAP} tbr_gen_state_t;

endpackage

// file: hw/tbr_regs.sv
// Purpose : 10Base-T control/status and packet self-test registers on AHB-Lite
// Assumes : Single word transfers; prbs_err_byte on hclk
// Notes   : Reads take one wait state so side effects and data line up

// Function
// - Bit 13 selects reduced 10Base-T receive threshold
// - Bits 12:9 set squelch, 50 mV steps
// - Bit 7 stops normal link pulses
// - Bit 4 reads one on inverted polarity
// - Polarity mirrored; tenbase read clears both copies
// - Bit 0 disables jabber, 10Base-T only
// - Reserved bits ignore writes, read zero
// - Bits 15:8 count checker error bytes
// - Control bit 0/1 write freezes shown count
// - Count mode zero saturates counter at top
// - Writing bit 15 snapshots then clears counter
// - Bits 7:0 set inter-packet gap bytes
// - Bits 10:0 set generated packet length
module tbr_regs
    import tbr_pkg::*;
(
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic [31:0]        hrdata,
    output logic               hreadyout,
    output logic               hresp,
    input  wire logic          rx_pol_inverted,
    input  wire logic          prbs_err_byte,
    output tbr_tenbase_t       tenbase_cfg,
    output logic               gen_byte,
    output logic               gen_sop,
    output logic               gen_done,
    output logic               irq
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    tbr_req_t     wreq;          // Write waiting for its data phase
    tbr_req_t     next_wreq;
    logic         rd_pend;       // Read in its wait cycle
    logic         next_rd_pend;
    logic [7:0]   rd_idx;        // Index of that read
    logic [7:0]   next_rd_idx;
    logic [31:0]  next_hrdata;
    logic         next_hreadyout;
    tbr_tenbase_t next_tenbase;
    logic [7:0]   gap;           // selftest_gap_bytes
    logic [7:0]   next_gap;
    logic [10:0]  len;           // selftest_frame_bytes
    logic [10:0]  next_len;
    logic [2:0]   ctrl;          // run, checker enable, count mode
    logic [2:0]   next_ctrl;
    logic [7:0]   err_cnt;       // Running error counter
    logic [7:0]   next_err_cnt;
    logic [7:0]   err_shown;     // selftest_error_bytes as read
    logic [7:0]   next_err_shown;
    logic         pol_flag;      // Sticky inverted-polarity flag
    logic         next_pol_flag;
    logic [IRQ_W-1:0] irq_stat;  // Sticky events
    logic [IRQ_W-1:0] next_irq_stat;
    logic [IRQ_W-1:0] irq_mask;  // Event enables
    logic [IRQ_W-1:0] next_irq_mask;
    logic         next_irq;
    logic         pol_s1;        // Synchroniser first stage
    logic         pol_s2;        // Synchroniser second stage
    logic [3:0]   byte_div;      // Byte-rate divider
    logic [3:0]   next_byte_div;
    logic         byte_en;       // One pulse per byte time
    logic         next_byte_en;

    localparam logic [3:0] BYTE_LAST = 4'(BYTE_CYCLES - 1);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Address phase of a transfer aimed at this slave
    function automatic logic take_phase(input logic sel, input logic [1:0] trans, input logic rdy);
        take_phase = sel && trans[1] && rdy;
    endfunction

    // Squelch code limited to the 600 mV top of the range
    function automatic logic [3:0] sq_clamp(input logic [3:0] v);
        sq_clamp = (v > SQ_MAX) ? SQ_MAX : v;
    endfunction

    // Read view of each register; unused bits stay zero
    function automatic logic [31:0] read_view(input logic [7:0] idx);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (idx)
            IDX_TENBASE: begin
                v[TB_RXTH_BIT]            = tenbase_cfg.lower_rx_threshold_en;
                v[TB_SQ_LSB +: 4]         = tenbase_cfg.squelch_level;
                v[TB_NLP_BIT]             = tenbase_cfg.link_pulse_tx_off;
                v[TB_POL_BIT]             = pol_flag;
                v[TB_JAB_BIT]             = tenbase_cfg.jabber_off;
            end
            IDX_PHY_STATUS:    v[PS_POL_BIT] = pol_flag;
            IDX_ERRGAP:        v[15:0] = {err_shown, gap};
            IDX_PKTLEN:        v[10:0] = len;
            IDX_SELFTEST_CTRL: v[2:0]  = ctrl;
            IDX_IRQ_STATUS:    v[IRQ_W-1:0] = irq_stat;
            IDX_IRQ_MASK:      v[IRQ_W-1:0] = irq_mask;
            default:           v = 32'h0000_0000;
        endcase
        read_view = v;
    endfunction

    // ------------------------------------------------------------------
    // Polarity synchroniser, input from the receive front end
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pol_s1 <= 1'b0;
            pol_s2 <= 1'b0;
        end else begin
            pol_s1 <= rx_pol_inverted;
            pol_s2 <= pol_s1;
        end
    end

    // ------------------------------------------------------------------
    // Next-state logic for bus, registers, counter and events
    // ------------------------------------------------------------------
    always_comb begin
        logic       cnt_inc;
        logic       pol_clr;
        logic [IRQ_W-1:0] ev;
        logic [IRQ_W-1:0] w1c;
        cnt_inc        = 1'b0;
        pol_clr        = 1'b0;
        ev             = '0;
        w1c            = '0;
        next_wreq      = wreq;
        next_rd_pend   = 1'b0;
        next_rd_idx    = rd_idx;
        next_hrdata    = hrdata;
        next_hreadyout = 1'b1;
        next_tenbase   = tenbase_cfg;
        next_gap       = gap;
        next_len       = len;
        next_ctrl      = ctrl;
        next_err_cnt   = err_cnt;
        next_err_shown = err_shown;
        next_irq_mask  = irq_mask;

        // Byte-rate enable for the generator
        next_byte_en  = (byte_div == BYTE_LAST);
        next_byte_div = next_byte_en ? 4'h0 : byte_div + 4'h1;

        // Address phase; reads hold hready low for one cycle
        if (hready) begin
            next_wreq.valid = take_phase(hsel, htrans, hready) && hwrite;
            next_wreq.idx   = haddr[9:2];
        end
        if (take_phase(hsel, htrans, hready) && !hwrite) begin
            next_rd_pend   = 1'b1;
            next_rd_idx    = haddr[9:2];
            next_hreadyout = 1'b0;
        end

        // Read wait cycle: register the data and apply read side effects
        if (rd_pend) begin
            next_hrdata = read_view(rd_idx);
            if (rd_idx == IDX_TENBASE) begin
                pol_clr = 1'b1;
            end
        end

        // Running error counter
        if (ctrl[CT_CHK_BIT] && prbs_err_byte) begin
            if (!ctrl[CT_MODE_BIT] && err_cnt == ERR_MAX) begin
                cnt_inc = 1'b0;
            end else begin
                cnt_inc = 1'b1;
            end
        end
        if (cnt_inc) begin
            next_err_cnt = err_cnt + 8'h01;
            ev[IRQ_SAT]  = !ctrl[CT_MODE_BIT] && (err_cnt == ERR_MAX - 8'h01);
        end

        // Write data phase; data bits outside each field are dropped
        if (wreq.valid) begin
            case (wreq.idx)
                IDX_TENBASE: begin
                    next_tenbase.lower_rx_threshold_en = hwdata[TB_RXTH_BIT];
                    next_tenbase.squelch_level = sq_clamp(hwdata[TB_SQ_LSB +: 4]);
                    next_tenbase.link_pulse_tx_off = hwdata[TB_NLP_BIT];
                    next_tenbase.jabber_off = hwdata[TB_JAB_BIT];
                end
                IDX_ERRGAP: begin
                    next_gap = hwdata[7:0];
                    if (hwdata[EG_CLR_BIT]) begin
                        // Snapshot, then restart; same-cycle error kept
                        next_err_shown = err_cnt;
                        next_err_cnt   = cnt_inc ? 8'h01 : 8'h00;
                    end
                end
                IDX_PKTLEN:        next_len = hwdata[10:0];
                IDX_SELFTEST_CTRL: begin
                    next_ctrl      = hwdata[2:0];
                    next_err_shown = err_cnt;
                end
                IDX_IRQ_STATUS:    w1c = hwdata[IRQ_W-1:0];
                IDX_IRQ_MASK:      next_irq_mask = hwdata[IRQ_W-1:0];
                default: begin
                    // Unmapped or read-only: ignored, still OKAY
                    next_gap = gap;
                end
            endcase
        end

        // Polarity flag: a new detection wins over the read clear
        next_pol_flag = (pol_flag && !pol_clr) || pol_s2;
        ev[IRQ_POL]   = pol_s2 && (!pol_flag || pol_clr);
        ev[IRQ_PKT]   = gen_done;

        // Sticky events: set wins over the write-one clear
        next_irq_stat = (irq_stat & ~w1c) | ev;
        next_irq      = |(next_irq_stat & next_irq_mask);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wreq        <= '0;
            rd_pend     <= 1'b0;
            rd_idx      <= 8'h00;
            hrdata      <= 32'h0000_0000;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            tenbase_cfg <= '{lower_rx_threshold_en: 1'b0, squelch_level: SQ_RESET,
                             link_pulse_tx_off: 1'b0, jabber_off: 1'b0};
            gap         <= GAP_RESET;
            len         <= LEN_RESET;
            ctrl        <= 3'h0;
            err_cnt     <= 8'h00;
            err_shown   <= 8'h00;
            pol_flag    <= 1'b0;
            irq_stat    <= '0;
            irq_mask    <= '0;
            irq         <= 1'b0;
            byte_div    <= 4'h0;
            byte_en     <= 1'b0;
        end else begin
            wreq        <= next_wreq;
            rd_pend     <= next_rd_pend;
            rd_idx      <= next_rd_idx;
            hrdata      <= next_hrdata;
            hreadyout   <= next_hreadyout;
            hresp       <= 1'b0;
            tenbase_cfg <= next_tenbase;
            gap         <= next_gap;
            len         <= next_len;
            ctrl        <= next_ctrl;
            err_cnt     <= next_err_cnt;
            err_shown   <= next_err_shown;
            pol_flag    <= next_pol_flag;
            irq_stat    <= next_irq_stat;
            irq_mask    <= next_irq_mask;
            irq         <= next_irq;
            byte_div    <= next_byte_div;
            byte_en     <= next_byte_en;
        end
    end

    // ------------------------------------------------------------------
    // Packet generator, runs while the run bit is set
    // ------------------------------------------------------------------
    tbr_gen u_gen (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .byte_en     (byte_en),
        .run         (ctrl[CT_RUN_BIT]),
        .frame_bytes (len),
        .gap_bytes   (gap),
        .gen_byte    (gen_byte),
        .gen_sop     (gen_sop),
        .gen_done    (gen_done)
    );

endmodule

// file: test/tb.sv
// Purpose : Bench for the tenbase and self-test registers
// Assumes : hready fed back from hreadyout, single slave
// Notes   : Rows, then reset, polarity, counter, generator
module tb
    import tbr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] idx; logic [31:0] wd; logic [31:0] ex;} tbr_row_t;
    logic         hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rx_pol_inverted = 0, prbs_err_byte = 0;
    logic [31:0]  haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0]   htrans = '0;
    logic         hreadyout, hresp, gen_byte, gen_sop, gen_done, irq;
    tbr_tenbase_t tenbase_cfg;
    int           err_total = 0, compares = 0, cyc, nb;
    // Write, expected read back
    tbr_row_t rows [7] = '{'{IDX_TENBASE, 32'hffff, 32'h3081}, '{IDX_TENBASE, 32'h2a81, 32'h2a81},
        '{IDX_TENBASE, 32'h1000, 32'h1000}, '{IDX_ERRGAP, 32'h7f33, 32'h0033}, '{IDX_PKTLEN, 32'hffff, 32'h07ff},
        '{IDX_IRQ_MASK, 32'hffff, 32'h0007}, '{8'h05, 32'hffff, 32'h0000}};
    always #5 hclk = ~hclk;
    tbr_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .rx_pol_inverted(rx_pol_inverted), .prbs_err_byte(prbs_err_byte), .tenbase_cfg(tenbase_cfg),
        .gen_byte(gen_byte), .gen_sop(gen_sop), .gen_done(gen_done), .irq(irq));
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic test_done;
        $display("mismatches %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] ex);
        compares++;
        if (seen !== ex) begin
            err_total++;
            $display("FAIL t=%0t seen %h expected %h", $time, seen, ex);
        end
    endtask
    // Bounded wait for hready high
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            err_total++;
            $display("FAIL t=%0t bus never ready", $time);
            test_done;
        end
    endtask
    // One word transfer, started after a rising edge
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {22'h0, idx, 2'b00};
        wait_rdy;
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy;
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d);
    endtask
    task automatic rc(input logic [7:0] idx, input logic [31:0] ex);
        bus(1'b0, idx, 32'h0);
        chk(rd, ex);
    endtask
    // One-cycle error pulses, quiet cycle between
    task automatic errs(input int n);
        repeat (n) begin
            prbs_err_byte <= 1'b1;
            @(posedge hclk);
            prbs_err_byte <= 1'b0;
            @(posedge hclk);
        end
    endtask
    // Cycles and bytes between packet starts
    task automatic meas(output int c, output int b);
        int n;
        n = 0;
        c = 0;
        b = 0;
        while (gen_sop !== 1'b1 && n < 2000) begin
            @(posedge hclk);
            n++;
        end
        do begin
            @(posedge hclk);
            c++;
            b += (gen_byte === 1'b1);
        end while (gen_sop !== 1'b1 && c < 2000);
        if (n >= 2000 || c >= 2000) begin
            err_total++;
            $display("FAIL t=%0t no packet start", $time);
            test_done;
        end
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (rows[i]) begin
            wr(rows[i].idx, rows[i].wd);
            rc(rows[i].idx, rows[i].ex);
        end
        // Mid-run reset, then reset values
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk({25'h0, tenbase_cfg}, 32'h0);
        rc(IDX_TENBASE, 32'h0);
        rc(IDX_ERRGAP, 32'h7d);
        rc(IDX_PKTLEN, 32'h5dc);
        // Status read keeps polarity, tenbase read clears
        rx_pol_inverted <= 1'b1;
        repeat (6) @(posedge hclk);
        rx_pol_inverted <= 1'b0;
        repeat (6) @(posedge hclk);
        rc(IDX_PHY_STATUS, 32'h1000);
        rc(IDX_PHY_STATUS, 32'h1000);
        chk({31'h0, irq}, 32'h0);
        wr(IDX_IRQ_MASK, 32'h1);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h1);
        rc(IDX_TENBASE, 32'h10);
        rc(IDX_TENBASE, 32'h0);
        rc(IDX_PHY_STATUS, 32'h0);
        rc(IDX_IRQ_STATUS, 32'h1);
        wr(IDX_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        // Counter: freeze, saturate, snapshot, clear
        wr(IDX_SELFTEST_CTRL, 32'h2);
        errs(300);
        rc(IDX_ERRGAP, 32'h7d);
        wr(IDX_ERRGAP, 32'h807d);
        rc(IDX_ERRGAP, 32'hff7d);
        errs(5);
        rc(IDX_ERRGAP, 32'hff7d);
        wr(IDX_SELFTEST_CTRL, 32'h2);
        rc(IDX_ERRGAP, 32'h057d);
        // Generator: short packets and gap, new length
        wr(IDX_PKTLEN, 32'h3);
        wr(IDX_ERRGAP, 32'h2);
        wr(IDX_SELFTEST_CTRL, 32'h1);
        meas(cyc, nb);
        chk(cyc, 32'd40);
        chk(nb, 32'd3);
        wr(IDX_PKTLEN, 32'h5);
        meas(cyc, nb);
        meas(cyc, nb);
        chk(cyc, 32'd56);
        chk(nb, 32'd5);
        rc(IDX_IRQ_STATUS, 32'h6);
        wr(IDX_SELFTEST_CTRL, 32'h0);
        test_done;
    end
endmodule

// file: test/tbr_regs_chk.sv
// Purpose : Bus, tenbase and generator checks on tbr_regs ports
// Assumes : One clock domain, reads take one wait state
// Notes   : Helpers track reads and tenbase writes
module tbr_regs_chk
    import tbr_pkg::*;
(
    input wire logic          hclk,
    input wire logic          hresetn,
    input wire logic          hsel,
    input wire logic [31:0]   haddr,
    input wire logic [1:0]    htrans,
    input wire logic          hwrite,
    input wire logic [31:0]   hwdata,
    input wire logic          hready,
    input wire logic [31:0]   hrdata,
    input wire logic          hreadyout,
    input wire logic          hresp,
    input wire tbr_tenbase_t  tenbase_cfg,
    input wire logic          gen_byte,
    input wire logic          gen_sop
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ------------------------------------------------------------------
    // Helper state
    // ------------------------------------------------------------------
    logic         taken;                     // Address phase accepted
    logic         rd_q, next_rd_q;           // Read data phase
    logic [7:0]   rd_idx, next_rd_idx;       // Index of that read
    logic         tbw, next_tbw;             // Tenbase write data phase
    logic         tbw_d, next_tbw_d;         // Cycle the new config shows
    tbr_tenbase_t exp_cfg, next_exp_cfg;     // Config the write should give
    assign taken = hsel && htrans[1] && hready;
    // Next values; squelch clamped at top
    always_comb begin
        next_rd_q    = taken && !hwrite;
        next_rd_idx  = haddr[9:2];
        next_tbw     = taken && hwrite && (haddr[9:2] == IDX_TENBASE);
        next_tbw_d   = tbw;
        next_exp_cfg = exp_cfg;
        if (tbw) begin
            next_exp_cfg = {hwdata[13], ((hwdata[12:9] > SQ_MAX) ? SQ_MAX : hwdata[12:9]), hwdata[7], hwdata[0]};
        end
    end
    // Register only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q    <= 1'b0;
            rd_idx  <= 8'h00;
            tbw     <= 1'b0;
            tbw_d   <= 1'b0;
            exp_cfg <= '0;
        end else begin
            rd_q    <= next_rd_q;
            rd_idx  <= next_rd_idx;
            tbw     <= next_tbw;
            tbw_d   <= next_tbw_d;
            exp_cfg <= next_exp_cfg;
        end
    end
    sequence s_rd_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    sequence s_byte_quiet;
        !gen_byte [*7];
    endsequence
    AST_READ_WAIT:
        assert property (rd_q |-> s_rd_wait) else $error("read wait wrong");
    AST_WRITE_NOWAIT:
        assert property (taken && hwrite |=> hreadyout) else $error("write stalled");
    AST_HRESP_OKAY:
        assert property (hresp == 1'b0) else $error("response not okay");
    AST_UPPER_ZERO:
        assert property (rd_q |=> hrdata[31:16] == 16'h0) else $error("upper nonzero");
    AST_TB_RSVD:
        assert property (rd_q && rd_idx == IDX_TENBASE |=> (hrdata[15:0] & 16'hc16e) == 16'h0) else $error("tenbase spare set");
    AST_LEN_RSVD:
        assert property (rd_q && rd_idx == IDX_PKTLEN |=> hrdata[15:11] == 5'h0) else $error("length spare set");
    AST_CFG_HOLD:
        assert property (!tbw_d |-> $stable(tenbase_cfg)) else $error("config moved");
    AST_CFG_VALUE:
        assert property (tbw_d |-> tenbase_cfg == exp_cfg) else $error("config wrong");
    AST_SQ_MAX:
        assert property (tenbase_cfg.squelch_level <= SQ_MAX) else $error("squelch above top");
    AST_SOP_BYTE:
        assert property (gen_sop |-> gen_byte) else $error("start without byte");
    AST_BYTE_GAP:
        assert property (gen_byte |=> s_byte_quiet) else $error("bytes too close");
endmodule
bind tbr_regs tbr_regs_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .tenbase_cfg(tenbase_cfg), .gen_byte(gen_byte), .gen_sop(gen_sop));
